/* File: rtl/mocfg_pkg.sv */
`default_nettype none
package mocfg_pkg;
  // Address map boundaries (14-bit CPU address space)
  localparam logic [13:0] MOCFG_REG_LAST     = 14'h003f;
  localparam logic [13:0] MOCFG_DUAL_LAST    = 14'h000f;
  localparam logic [13:0] MOCFG_MISC_ADDR    = 14'h003e;
  localparam logic [13:0] MOCFG_RAM_FIRST    = 14'h0040;
  localparam logic [13:0] MOCFG_RAM_LAST     = 14'h013f;
  localparam logic [13:0] MOCFG_UROM_FIRST   = 14'h1000;
  localparam logic [13:0] MOCFG_UROM_LAST    = 14'h2fff;
  localparam logic [13:0] MOCFG_SCROM_FIRST  = 14'h3e00;
  localparam logic [13:0] MOCFG_SCROM_LAST   = 14'h3fef;
  localparam logic [13:0] MOCFG_UVEC_FIRST   = 14'h3ff0;
  localparam logic [13:0] MOCFG_UVEC_LAST    = 14'h3fff;
  localparam logic [13:0] MOCFG_SCVEC_OFFSET = 14'h0010;
  // Option map offsets
  localparam logic [3:0]  MOCFG_OPT_PULLUP_AB = 4'h8;
  localparam logic [3:0]  MOCFG_OPT_PULLUP_C  = 4'h9;
  localparam logic [3:0]  MOCFG_OPT_OD_ADE    = 4'ha;
  localparam logic [3:0]  MOCFG_OPT_OD_C      = 4'hb;
  localparam logic [3:0]  MOCFG_OPT_KWU       = 4'he;
  localparam logic [3:0]  MOCFG_OPT_MASK_OPTION_STATUS      = 4'hf;
  // Field positions and implemented-bit masks
  localparam int          MOCFG_OPTION_MAP_SELECT_BIT      = 0;
  localparam logic [7:0]  MOCFG_PULLUP_AB_MSK = 8'h0f;
  localparam logic [7:0]  MOCFG_OD_ADE_MSK    = 8'hf3;
  localparam logic [7:0]  MOCFG_OD_C_MSK      = 8'h3f;
  localparam int          MOCFG_OD_DH_BIT     = 7;
  localparam int          MOCFG_OD_DL_BIT     = 6;
  localparam int          MOCFG_OD_EH_BIT     = 5;
  localparam int          MOCFG_OD_EL_BIT     = 4;
  localparam int          MOCFG_OD_AH_BIT     = 1;
  localparam int          MOCFG_OD_AL_BIT     = 0;
  // Reset values
  localparam logic [7:0]  MOCFG_RST_VAL       = 8'h00;
  localparam logic        MOCFG_OPTION_MAP_SELECT_RST      = 1'b0;
  // Timing counts: edges after reset release before the mode is taken
  localparam logic [2:0]  MOCFG_MODE_SETTLE   = 3'h4;
  // Mode encoding
  typedef enum logic [1:0] {
    MOCFG_MODE_USER  = 2'b01,
    MOCFG_MODE_CHECK = 2'b10
  } mocfg_mode_e;
endpackage : mocfg_pkg
`default_nettype wire

/* File: rtl/mocfg_top.sv */
`default_nettype none
module mocfg_top
  import mocfg_pkg::*;
#(
  parameter logic RESET_PULLUP_OPT = 1'b0,
  parameter logic MAIN_OSC_RES_OPT = 1'b0,
  parameter logic AUX_OSC_RES_OPT  = 1'b0
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Mode strap pins
  input  wire logic        ext_interrupt_pin_one_test_level_i,
  input  wire logic        ext_interrupt_pin_two_pin_i,
  // CPU internal bus
  input  wire logic [13:0] cpu_addr_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic [7:0]  cpu_wdata_i,
  input  wire logic        vector_fetch_i,
  output var  logic [7:0]  cfg_rdata_o,
  output logic             cfg_rvalid_o,
  // Chip selects
  output logic             sel_main_regs_o,
  output logic             sel_ram_o,
  output logic             sel_user_rom_o,
  output logic             sel_check_rom_o,
  output logic             sel_user_vec_o,
  output logic [13:0]      rom_addr_o,
  // Mode status
  output logic             single_chip_user_mode_o,
  output logic             privileged_open_o,
  output logic             option_map_select_o,
  // Port context
  input  wire logic [7:0]  porta_direction_bits_i,
  input  wire logic [5:0]  portc_direction_bit_i,
  input  wire logic        lcd_ctrl_portd_high_select_i,
  input  wire logic        lcd_ctrl_porte_high_select_i,
  input  wire logic        lcd_ctrl_porte_low_select_i,
  input  wire logic [2:0]  lcd_backplane_line_used_i,
  input  wire logic [7:0]  key_wakeup_input_line_i,
  // Pin configuration
  output logic [7:0]       pullup_porta_o,
  output logic [7:0]       pullup_portb_o,
  output logic [7:0]       pullup_portc_o,
  output logic [7:0]       opendrain_porta_o,
  output logic [5:0]       opendrain_portc_o,
  output logic [7:1]       opendrain_portd_o,
  output logic [7:0]       opendrain_porte_o,
  output logic [7:0]       key_wakeup_active_o
);

  // Registers
  logic [7:0]  pullup_ctrl_ports_ab_reg;
  logic [7:0]  pullup_ctrl_port_c_reg;
  logic [7:0]  opendrain_ctrl_ports_ade_reg;
  logic [7:0]  opendrain_ctrl_port_c_reg;
  logic [7:0]  key_wakeup_input_enable_reg;
  logic        option_map_select_reg;
  mocfg_mode_e mode_reg;
  logic [2:0]  ext_interrupt_pin_one_sync_reg;
  logic [2:0]  ext_interrupt_pin_two_sync_reg;
  logic        ext_interrupt_pin_one_filt_reg;
  logic        ext_interrupt_pin_two_filt_reg;
  logic        rst_seen_reg;
  logic [2:0]  settle_reg;
  logic [7:0]  rdata_reg;
  logic        rvalid_reg;

  // Address range check
  function automatic logic in_range(input logic [13:0] a,
                                    input logic [13:0] lo,
                                    input logic [13:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Decode
  wire logic is_check   = (mode_reg == MOCFG_MODE_CHECK);
  wire logic in_regs    = cpu_addr_i <= MOCFG_REG_LAST;
  wire logic in_dual    = cpu_addr_i <= MOCFG_DUAL_LAST;
  wire logic opt_hit    = in_dual && option_map_select_reg;
  wire logic misc_hit   = cpu_addr_i == MOCFG_MISC_ADDR;
  wire logic [3:0] opt_off = cpu_addr_i[3:0];
  wire logic wr_opt     = cpu_wr_i && opt_hit;
  wire logic wr_misc    = cpu_wr_i && misc_hit;
  wire logic [13:0] vec_addr = cpu_addr_i - MOCFG_SCVEC_OFFSET;

  // Memory regions; each range is inclusive at both ends
  wire logic in_ram     = in_range(cpu_addr_i, MOCFG_RAM_FIRST, MOCFG_RAM_LAST);
  wire logic in_urom    = in_range(cpu_addr_i, MOCFG_UROM_FIRST, MOCFG_UROM_LAST);
  wire logic in_uvec    = in_range(cpu_addr_i, MOCFG_UVEC_FIRST, MOCFG_UVEC_LAST);
  wire logic in_scrom   = in_range(cpu_addr_i, MOCFG_SCROM_FIRST, MOCFG_SCROM_LAST);

  // Vector fetches in self-check move down sixteen bytes, so the
  // self-check program never runs from the user vector table
  wire logic remap_vec  = is_check && vector_fetch_i;

  // Chip selects; self-check steers vector fetches into its own ROM
  // The miscellaneous register is answered here, not by the main bank
  assign sel_main_regs_o = in_regs && !opt_hit && !misc_hit;
  assign sel_ram_o       = in_ram;
  assign sel_user_rom_o  = in_urom;
  assign sel_user_vec_o  = in_uvec && !remap_vec;
  // Outside self-check the check ROM is never selected
  assign sel_check_rom_o = (in_scrom && is_check) || (remap_vec && in_uvec);
  assign rom_addr_o      = remap_vec ? vec_addr : cpu_addr_i;

  // Mode outputs; during reset report single-chip
  assign single_chip_user_mode_o = !rst_n_i || (mode_reg == MOCFG_MODE_USER);
  assign privileged_open_o       = rst_n_i && is_check;
  assign option_map_select_o     = option_map_select_reg;

  // Strap pin one: three-stage shift, accepted once the last two agree
  // A glitch shorter than one clock never reaches the filtered value
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_interrupt_pin_one_sync_reg <= 3'h0;
      ext_interrupt_pin_one_filt_reg <= 1'b0;
    end else begin
      ext_interrupt_pin_one_sync_reg <= {ext_interrupt_pin_one_sync_reg[1:0], ext_interrupt_pin_one_test_level_i};
      if (ext_interrupt_pin_one_sync_reg[1] == ext_interrupt_pin_one_sync_reg[2]) begin
        ext_interrupt_pin_one_filt_reg <= ext_interrupt_pin_one_sync_reg[2];
      end
    end
  end

  // Strap pin two: same three-stage shift and agreement filter
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_interrupt_pin_two_sync_reg <= 3'h0;
      ext_interrupt_pin_two_filt_reg <= 1'b0;
    end else begin
      ext_interrupt_pin_two_sync_reg <= {ext_interrupt_pin_two_sync_reg[1:0], ext_interrupt_pin_two_pin_i};
      if (ext_interrupt_pin_two_sync_reg[1] == ext_interrupt_pin_two_sync_reg[2]) begin
        ext_interrupt_pin_two_filt_reg <= ext_interrupt_pin_two_sync_reg[2];
      end
    end
  end

  // Mode latch: the strap filter holds the pin level from the fourth
  // edge after release, so the mode is taken at the fifth and never again
  // The pins must stay put only for the first two clocks after release
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg     <= MOCFG_MODE_USER;
      settle_reg   <= 3'h0;
      rst_seen_reg <= 1'b0;
    end else if (!rst_seen_reg) begin
      settle_reg <= settle_reg + 3'h1;
      if (settle_reg == MOCFG_MODE_SETTLE) begin
        rst_seen_reg <= 1'b1;
        mode_reg     <= (ext_interrupt_pin_one_filt_reg && ext_interrupt_pin_two_filt_reg) ? MOCFG_MODE_CHECK
                                                         : MOCFG_MODE_USER;
      end
    end
  end

  // Option map select bit in the miscellaneous register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      option_map_select_reg <= MOCFG_OPTION_MAP_SELECT_RST;
    end else if (wr_misc) begin
      option_map_select_reg <= cpu_wdata_i[MOCFG_OPTION_MAP_SELECT_BIT];
    end
  end

  // Option map hits, one per register; other offsets hit nothing here
  wire logic hit_pullup_ab = opt_hit && (opt_off == MOCFG_OPT_PULLUP_AB);
  wire logic hit_pullup_c  = opt_hit && (opt_off == MOCFG_OPT_PULLUP_C);
  wire logic hit_od_ade    = opt_hit && (opt_off == MOCFG_OPT_OD_ADE);
  wire logic hit_od_c      = opt_hit && (opt_off == MOCFG_OPT_OD_C);
  wire logic hit_kwu       = opt_hit && (opt_off == MOCFG_OPT_KWU);
  wire logic hit_mask_option_status      = opt_hit && (opt_off == MOCFG_OPT_MASK_OPTION_STATUS);

  // Write enables; a write to the status offset or a gap does nothing
  wire logic wr_pullup_ab  = wr_opt && hit_pullup_ab;
  wire logic wr_pullup_c   = wr_opt && hit_pullup_c;
  wire logic wr_od_ade     = wr_opt && hit_od_ade;
  wire logic wr_od_c       = wr_opt && hit_od_c;
  wire logic wr_kwu        = wr_opt && hit_kwu;

  // Nibble pullups for ports A and B; upper four bits stay zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pullup_ctrl_ports_ab_reg <= MOCFG_RST_VAL;
    end else if (wr_pullup_ab) begin
      pullup_ctrl_ports_ab_reg <= cpu_wdata_i & MOCFG_PULLUP_AB_MSK;
    end
  end

  // Per-line pullups for port C
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pullup_ctrl_port_c_reg <= MOCFG_RST_VAL;
    end else if (wr_pullup_c) begin
      pullup_ctrl_port_c_reg <= cpu_wdata_i;
    end
  end

  // Open-drain nibbles for ports A, D and E; bits 3 and 2 stay zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opendrain_ctrl_ports_ade_reg <= MOCFG_RST_VAL;
    end else if (wr_od_ade) begin
      opendrain_ctrl_ports_ade_reg <= cpu_wdata_i & MOCFG_OD_ADE_MSK;
    end
  end

  // Per-line open-drain for port C; bits 7 and 6 stay zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opendrain_ctrl_port_c_reg <= MOCFG_RST_VAL;
    end else if (wr_od_c) begin
      opendrain_ctrl_port_c_reg <= cpu_wdata_i & MOCFG_OD_C_MSK;
    end
  end

  // Key wakeup enables, one per port B line
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_wakeup_input_enable_reg <= MOCFG_RST_VAL;
    end else if (wr_kwu) begin
      key_wakeup_input_enable_reg <= cpu_wdata_i;
    end
  end

  // Read data selection; anything unimplemented reads zero
  // The status byte is built from parameters and has no storage
  wire logic [7:0] mask_option_status_val = {RESET_PULLUP_OPT, MAIN_OSC_RES_OPT, AUX_OSC_RES_OPT,
                               5'h00};
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    if (misc_hit) begin
      rd_next = {7'h00, option_map_select_reg};
    end else if (hit_pullup_ab) begin
      rd_next = pullup_ctrl_ports_ab_reg;
    end else if (hit_pullup_c) begin
      rd_next = pullup_ctrl_port_c_reg;
    end else if (hit_od_ade) begin
      rd_next = opendrain_ctrl_ports_ade_reg;
    end else if (hit_od_c) begin
      rd_next = opendrain_ctrl_port_c_reg;
    end else if (hit_kwu) begin
      rd_next = key_wakeup_input_enable_reg;
    end else if (hit_mask_option_status) begin
      rd_next = mask_option_status_val;
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= cpu_rd_i && (opt_hit || misc_hit);
      if (cpu_rd_i) begin
        rdata_reg <= rd_next;
      end
    end
  end
  assign cfg_rdata_o  = rdata_reg;
  assign cfg_rvalid_o = rvalid_reg;

  // Pullup fan-out per nibble and per line
  assign pullup_porta_o = {{4{pullup_ctrl_ports_ab_reg[1]}}, {4{pullup_ctrl_ports_ab_reg[0]}}};
  assign pullup_portb_o = {{4{pullup_ctrl_ports_ab_reg[3]}},
                           {4{pullup_ctrl_ports_ab_reg[2]}}};
  assign pullup_portc_o = pullup_ctrl_port_c_reg;

  // Open-drain qualification by direction and LCD use
  wire logic od_ah = opendrain_ctrl_ports_ade_reg[MOCFG_OD_AH_BIT];
  wire logic od_al = opendrain_ctrl_ports_ade_reg[MOCFG_OD_AL_BIT];
  wire logic od_dh = opendrain_ctrl_ports_ade_reg[MOCFG_OD_DH_BIT];
  wire logic od_dl = opendrain_ctrl_ports_ade_reg[MOCFG_OD_DL_BIT];
  wire logic od_eh = opendrain_ctrl_ports_ade_reg[MOCFG_OD_EH_BIT];
  wire logic od_el = opendrain_ctrl_ports_ade_reg[MOCFG_OD_EL_BIT];
  assign opendrain_porta_o = porta_direction_bits_i & {{4{od_ah}}, {4{od_al}}};
  assign opendrain_portc_o = portc_direction_bit_i & opendrain_ctrl_port_c_reg[5:0];
  assign opendrain_portd_o[7:4] = {4{od_dh && lcd_ctrl_portd_high_select_i}};
  assign opendrain_portd_o[3:1] = {3{od_dl}} & ~lcd_backplane_line_used_i;
  assign opendrain_porte_o = {{4{od_eh && lcd_ctrl_porte_high_select_i}},
                              {4{od_el && lcd_ctrl_porte_low_select_i}}};

  // Key wakeup gating
  assign key_wakeup_active_o = key_wakeup_input_line_i & key_wakeup_input_enable_reg;

endmodule : mocfg_top
`default_nettype wire

/* File: bench/mocfg_properties.sv */
`default_nettype none
module mocfg_properties
  import mocfg_pkg::*;
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // CPU bus
  input wire logic [13:0] cpu_addr_i,
  input wire logic        cpu_wr_i,
  input wire logic        cpu_rd_i,
  input wire logic [7:0]  cpu_wdata_i,
  input wire logic        cfg_rvalid_o,
  // Selects and mode
  input wire logic        sel_main_regs_o,
  input wire logic        sel_ram_o,
  input wire logic        sel_check_rom_o,
  input wire logic        single_chip_user_mode_o,
  input wire logic        privileged_open_o,
  input wire logic        option_map_select_o,
  // Port context
  input wire logic [7:0]  porta_direction_bits_i,
  input wire logic [5:0]  portc_direction_bit_i,
  input wire logic [7:0]  opendrain_porta_o,
  input wire logic [5:0]  opendrain_portc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles since reset release, saturating once the mode has settled
  logic [2:0] settle_reg;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) settle_reg <= 3'h0;
    else if (settle_reg != 3'h7) settle_reg <= settle_reg + 3'h1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_misc_read_answer: assert property (
    cpu_rd_i && cpu_addr_i == MOCFG_MISC_ADDR |=> cfg_rvalid_o) else $error("misc read lost");
  chk_ram_read_silent: assert property (
    cpu_rd_i && cpu_addr_i inside {[MOCFG_RAM_FIRST:MOCFG_RAM_LAST]} |=> !cfg_rvalid_o)
    else $error("answer to ram read");
  chk_select_bit_write: assert property (
    cpu_wr_i && cpu_addr_i == MOCFG_MISC_ADDR |=>
      option_map_select_o == $past(cpu_wdata_i[MOCFG_OPTION_MAP_SELECT_BIT])) else $error("select bit wrong");
  chk_mode_held: assert property (settle_reg == 3'h7 |-> $stable(single_chip_user_mode_o))
    else $error("mode changed after latch");
  chk_reset_user_pins: assert property (disable iff (1'b0)
    !rst_n_i |-> single_chip_user_mode_o && !privileged_open_o) else $error("not user in reset");
  chk_privilege_mode: assert property (privileged_open_o != single_chip_user_mode_o)
    else $error("privilege and mode disagree");
  chk_select_cleared: assert property ($rose(rst_n_i) |-> !option_map_select_o)
    else $error("select bit set after reset");
  chk_ram_decode: assert property (
    cpu_addr_i inside {[MOCFG_RAM_FIRST:MOCFG_RAM_LAST]} |-> sel_ram_o) else $error("ram miss");
  chk_main_decode: assert property (
    cpu_addr_i inside {[14'h0010:MOCFG_REG_LAST]} && cpu_addr_i != MOCFG_MISC_ADDR
      |-> sel_main_regs_o) else $error("reg miss");
  chk_check_rom_mode: assert property (sel_check_rom_o |-> privileged_open_o)
    else $error("check rom in user mode");
  chk_od_porta_dir: assert property ((opendrain_porta_o & ~porta_direction_bits_i) == 8'h00)
    else $error("port a open-drain on input");
  chk_od_portc_dir: assert property ((opendrain_portc_o & ~portc_direction_bit_i) == 6'h00)
    else $error("port c open-drain on input");
endmodule : mocfg_properties
bind mocfg_top mocfg_properties mocfg_properties_i (.*);
`default_nettype wire

/* File: bench/mocfg_cpu_model.sv */
`default_nettype none
module mocfg_cpu_model (
  // Bus clock
  input  wire logic        mclk_i,
  // Bus request
  output var  logic [13:0] addr_o,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [7:0]  wdata_o,
  output var  logic        vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {addr_o, wr_o, rd_o, wdata_o, vec_o} = '0;
  end
  // Places one request; c is write, read, vector fetch
  task automatic drive(input logic [13:0] a, input logic [2:0] c, input logic [7:0] d);
    addr_o = a;
    {wr_o, rd_o, vec_o} = c;
    wdata_o = d;
  endtask : drive
  // Released bus shows inverted leftovers, never the last value
  task automatic idle();
    {wr_o, rd_o, vec_o} = 3'b000;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask : idle
endmodule : mocfg_cpu_model
`default_nettype wire

/* File: bench/mocfg_top_tb.sv */
`default_nettype none
module mocfg_top_tb;
  import mocfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Design ports
  logic        mclk_i = 1'b0, rst_n_i = 1'b0, ext_interrupt_pin_one_test_level_i = 1'b0, ext_interrupt_pin_two_pin_i = 1'b0;
  logic [13:0] cpu_addr_i, rom_addr_o;
  logic        cpu_wr_i, cpu_rd_i, vector_fetch_i, cfg_rvalid_o, option_map_select_o;
  logic [7:0]  cpu_wdata_i, cfg_rdata_o, porta_direction_bits_i = 8'h00;
  logic [7:0]  key_wakeup_input_line_i = 8'h00, key_wakeup_active_o;
  logic [5:0]  portc_direction_bit_i = 6'h00, opendrain_portc_o;
  logic [2:0]  lcd_backplane_line_used_i = 3'h0;
  logic        lcd_ctrl_portd_high_select_i = 1'b0, lcd_ctrl_porte_high_select_i = 1'b0;
  logic        lcd_ctrl_porte_low_select_i = 1'b0, sel_main_regs_o, sel_ram_o, sel_user_rom_o;
  logic        sel_check_rom_o, sel_user_vec_o, single_chip_user_mode_o, privileged_open_o;
  logic [7:0]  pullup_porta_o, pullup_portb_o, pullup_portc_o, opendrain_porta_o, opendrain_porte_o;
  logic [7:1]  opendrain_portd_o;
  // Bench state
  logic [31:0] seed = 32'hbc40b25d;
  logic [7:0]  exp_q[$], v[6];
  logic [3:0]  offs[6] = '{MOCFG_OPT_PULLUP_AB, MOCFG_OPT_PULLUP_C, MOCFG_OPT_OD_ADE,
                           MOCFG_OPT_OD_C, MOCFG_OPT_KWU, MOCFG_OPT_MASK_OPTION_STATUS};
  logic [7:0]  msk[6] = '{MOCFG_PULLUP_AB_MSK, 8'hff, MOCFG_OD_ADE_MSK, MOCFG_OD_C_MSK, 8'hff, 8'h00};
  logic [13:0] da[9] = '{14'h0010, MOCFG_REG_LAST, MOCFG_RAM_FIRST, MOCFG_RAM_LAST, 14'h0140,
                         MOCFG_UROM_FIRST, MOCFG_UROM_LAST, MOCFG_SCROM_FIRST, MOCFG_UVEC_FIRST};
  logic [4:0]  ds[9] = '{5'h10, 5'h10, 5'h08, 5'h08, 5'h00, 5'h04, 5'h04, 5'h00, 5'h01};
  int          fails = 0, cmp_count = 0, cyc = 0;
  mocfg_top #(.RESET_PULLUP_OPT(1'b1), .MAIN_OSC_RES_OPT(1'b0), .AUX_OSC_RES_OPT(1'b1))
    mocfg_top_i (.*);
  mocfg_cpu_model mocfg_cpu_model_i (.mclk_i(mclk_i), .addr_o(cpu_addr_i), .wr_o(cpu_wr_i),
    .rd_o(cpu_rd_i), .wdata_o(cpu_wdata_i), .vec_o(vector_fetch_i));
  always #2.5 mclk_i = ~mclk_i;
  // Cuts a hang short
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic rst(input logic p1, input logic p2);
    rst_n_i = 1'b0;
    ext_interrupt_pin_one_test_level_i = p1;
    ext_interrupt_pin_two_pin_i = p2;
    repeat (5) @(negedge mclk_i);
    chk("mode in reset", 14'h1, 14'(single_chip_user_mode_o));
    rst_n_i = 1'b1;
    repeat (6) @(negedge mclk_i);
  endtask : rst
  task automatic acc(input logic [13:0] a, input logic [2:0] c, input logic [7:0] d);
    mocfg_cpu_model_i.drive(a, c, d);
    @(negedge mclk_i);
    mocfg_cpu_model_i.idle();
    @(negedge mclk_i);
  endtask : acc
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(a, 3'b010, 8'h00);
  endtask : rd
  task automatic dec(input logic [13:0] a, input logic f, input logic [4:0] s, input logic [13:0] r);
    mocfg_cpu_model_i.drive(a, {2'b01, f}, 8'h00);
    #1;
    chk("selects", 14'(s), 14'({sel_main_regs_o, sel_ram_o, sel_user_rom_o, sel_check_rom_o,
        sel_user_vec_o}));
    if (f) chk("vector address", r, rom_addr_o);
    @(negedge mclk_i);
    mocfg_cpu_model_i.idle();
    @(negedge mclk_i);
  endtask : dec
  // Random port context, then pin options against the register copies
  task automatic pins();
    logic [31:0] r;
    r = rnd();
    {porta_direction_bits_i, portc_direction_bit_i, lcd_backplane_line_used_i,
     lcd_ctrl_portd_high_select_i, lcd_ctrl_porte_high_select_i, lcd_ctrl_porte_low_select_i,
     key_wakeup_input_line_i} = r[27:0];
    #1;
    chk("pullup a", 14'({{4{v[0][1]}}, {4{v[0][0]}}}), 14'(pullup_porta_o));
    chk("pullup b", 14'({{4{v[0][3]}}, {4{v[0][2]}}}), 14'(pullup_portb_o));
    chk("pullup c", 14'(v[1]), 14'(pullup_portc_o));
    chk("od a", 14'({{4{v[2][1]}}, {4{v[2][0]}}} & porta_direction_bits_i),
        14'(opendrain_porta_o));
    chk("od c", 14'(v[3][5:0] & portc_direction_bit_i), 14'(opendrain_portc_o));
    chk("od e", 14'({{4{v[2][5] & lcd_ctrl_porte_high_select_i}},
        {4{v[2][4] & lcd_ctrl_porte_low_select_i}}}), 14'(opendrain_porte_o));
    chk("od d", 14'({{4{v[2][7] & lcd_ctrl_portd_high_select_i}},
        {3{v[2][6]}} & ~lcd_backplane_line_used_i}), 14'(opendrain_portd_o));
    chk("wakeup", 14'(key_wakeup_input_line_i & v[4]), 14'(key_wakeup_active_o));
    @(negedge mclk_i);
  endtask : pins
  // Pairs each read answer with the oldest noted expectation
  always @(negedge mclk_i) begin
    if (cfg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) chk("stray rvalid", 14'h0, 14'h1);
      else chk("read data", 14'(exp_q.pop_front()), 14'(cfg_rdata_o));
    end
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    rst(1'b0, 1'b0);
    rd(MOCFG_MISC_ADDR, 8'h00);
    acc(MOCFG_MISC_ADDR, 3'b100, 8'hff);
    rd(MOCFG_MISC_ADDR, 8'h01);
    for (int k = 0; k < 6; k++) rd(14'(offs[k]), k == 5 ? 8'ha0 : 8'h00);
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      v[k] = (r[7:0] & msk[k]) | (k == 5 ? 8'ha0 : 8'h00);
      acc(14'(offs[k]), 3'b100, r[7:0]);
      rd(14'(offs[k]), v[k]);
    end
    repeat (4) pins();
    acc(MOCFG_MISC_ADDR, 3'b100, 8'h00);
    acc(14'(offs[0]), 3'b100, ~v[0]);
    acc(MOCFG_MISC_ADDR, 3'b100, 8'h01);
    rd(14'(offs[0]), v[0]);
    acc(MOCFG_MISC_ADDR, 3'b100, 8'h00);
    for (int i = 0; i < 9; i++) dec(da[i], 1'b0, ds[i], 14'h0);
    for (int m = 0; m < 4; m++) begin
      rst(m[1], m[0]);
      chk("mode", 14'(m != 3), 14'(single_chip_user_mode_o));
      chk("privilege", 14'(m == 3), 14'(privileged_open_o));
      chk("select after reset", 14'h0, 14'(option_map_select_o));
      ext_interrupt_pin_one_test_level_i = ~m[1];
      ext_interrupt_pin_two_pin_i = ~m[0];
      acc(MOCFG_MISC_ADDR, 3'b100, 8'hff);
      chk("mode kept", 14'(m != 3), 14'(single_chip_user_mode_o));
      dec(14'h3ffe, 1'b1, m == 3 ? 5'h02 : 5'h01, m == 3 ? 14'h3fee : 14'h3ffe);
    end
    chk("answers left", 14'h0, 14'(exp_q.size()));
    results();
  end
endmodule : mocfg_top_tb
`default_nettype wire
